// ==== core/udbs_core.sv ====
// Serial transceiver data buffer, receive FIFO and status flags
`timescale 1ns/1ns
`include "udbs_cfg.svh"
module udbs_core
  import udbs_pkg::*;
#(
  parameter int BAUD_W = 12 // Width of the baud divider
) (
  input wire logic i_clk_sys, // 250 MHz system clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rxd, // Serial receive pin
  output logic o_txd, // Serial transmit pin
  input wire logic i_tx_done_ack, // Transmit-complete interrupt taken
  output logic o_irq_rx,
  output logic o_irq_tx,
  output logic o_irq_empty
);

  // Elaboration check: the divider registers hold twelve bits
  if (BAUD_W != 12) begin : g_bad_width
    $error("udbs_core: BAUD_W must be 12");
  end

  udbs_state_s s_q; // Registered state
  udbs_state_s s_d; // Next state

  // ===================================================================
  // Helper functions
  // Keeps only the bits of the configured character size
  function automatic logic [7:0] size_mask(input logic [7:0] v,
                                            input logic [1:0] code);
    logic [7:0] m;
    m = 8'hff >> (2'd3 - code);
    return v & m;
  endfunction

  // Index of the last data bit, five to eight bits
  function automatic logic [2:0] last_bit(input logic [1:0] code);
    return 3'd4 + {1'b0, code};
  endfunction

  // Pin level for a transmit state
  function automatic logic tx_level(input udbs_tx_e st,
                                    input logic b0, input logic p);
    case (st)
      UDBS_TX_START: return 1'b0;
      UDBS_TX_DATA: return b0;
      UDBS_TX_PAR: return p;
      default: return 1'b1;
    endcase
  endfunction

  // ===================================================================
  // Decode and derived flags
  logic setup; // APB setup phase
  logic access; // APB access phase, always completes
  logic [7:0] idx; // Register index from the byte address
  logic mapped; // Address hits a register
  logic spi_mode; // Master SPI emulation selected
  logic udre; // Transmit buffer empty
  logic rxc; // Unread data in the receive buffer
  logic [7:0] status_val; // Status as software sees it
  logic [1:0] size_code; // Character size code
  logic pen; // Parity checking on
  logic brg_tick; // Oversample tick
  logic [3:0] os_last; // Last oversample tick of a bit
  logic [3:0] os_mid; // Mid-bit sample tick
  logic data_acc; // Any access to the data location
  logic rx_in; // Synchronised receive line
  udbs_char_s ch; // Character being committed

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign idx = i_paddr[9:2];
  assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr[11:10] == 2'b00) &&
    (idx == `UDBS_IDX_STATUS || idx == `UDBS_IDX_CTRLB ||
     idx == `UDBS_IDX_CTRLC || idx == `UDBS_IDX_BAUDL ||
     idx == `UDBS_IDX_BAUDH || idx == `UDBS_IDX_DATA);
  assign spi_mode = s_q.ctrlc[`UDBS_CC_MODE_HI:`UDBS_CC_MODE_LO] ==
    `UDBS_MODE_SPI;
  assign udre = !s_q.tx_hold_v; // [R11]
  assign rxc = s_q.count != 2'd0; // [R08]
  assign size_code = s_q.ctrlc[`UDBS_CC_SIZE_HI:`UDBS_CC_SIZE_LO];
  assign pen = s_q.ctrlc[`UDBS_CC_PEN];
  assign brg_tick = s_q.brg_cnt == s_q.baud; // [R23]
  assign os_last = s_q.u2x ? `UDBS_OS_LAST_DBL : `UDBS_OS_LAST_NORM; // [R20]
  assign os_mid = s_q.u2x ? `UDBS_OS_MID_DBL : `UDBS_OS_MID_NORM;
  assign data_acc = access && (idx == `UDBS_IDX_DATA) && mapped;
  assign rx_in = s_q.rx_sync;

  // Status: error bits come from the head entry, reserved in SPI mode
  always_comb begin
    status_val = 8'h00;
    status_val[`UDBS_ST_RXC] = rxc;
    status_val[`UDBS_ST_TXC] = s_q.txc;
    status_val[`UDBS_ST_UDRE] = udre;
    if (rxc && !spi_mode) begin // [R13] [R16] [R18]
      status_val[`UDBS_ST_FE] = s_q.fifo[0].fe;
      status_val[`UDBS_ST_DOR] = s_q.fifo[0].dor; // [R14]
      status_val[`UDBS_ST_PE] = s_q.fifo[0].pe; // [R15]
    end
    status_val[`UDBS_ST_U2X] = s_q.u2x;
    status_val[`UDBS_ST_MPCM] = s_q.mpcm;
  end

  // ===================================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    ch = '0;
    // Receive line synchroniser, two stages
    s_d.rx_meta = i_rxd;
    s_d.rx_sync = s_q.rx_meta;
    // Shared divider: tick every divider+1 clocks
    s_d.brg_cnt = brg_tick ? 12'h000 : s_q.brg_cnt + 12'h001; // [R19]

    // Read data captured in setup, valid in access phase
    if (setup) begin
      case (idx)
        `UDBS_IDX_STATUS: s_d.prdata = {24'h0, status_val};
        `UDBS_IDX_CTRLB: s_d.prdata = {24'h0, s_q.ctrlb};
        `UDBS_IDX_CTRLC: s_d.prdata = {24'h0, s_q.ctrlc};
        `UDBS_IDX_BAUDL: s_d.prdata = {24'h0, s_q.baud[7:0]};
        `UDBS_IDX_BAUDH: s_d.prdata = {28'h0, s_q.baud[11:8]};
        `UDBS_IDX_DATA: s_d.prdata = {24'h0, s_q.fifo[0].data}; // [R01]
        default: s_d.prdata = 32'h0000_0000;
      endcase
      if (!mapped) begin
        s_d.prdata = 32'h0000_0000;
      end
    end

    // Register writes at the access edge
    if (access && i_pwrite && mapped) begin
      case (idx)
        `UDBS_IDX_STATUS: begin
          // Error bits are read-only; software writes them as zero
          if (i_pwdata[`UDBS_ST_TXC]) begin // [R10]
            s_d.txc = 1'b0;
          end
          s_d.u2x = i_pwdata[`UDBS_ST_U2X];
          s_d.mpcm = i_pwdata[`UDBS_ST_MPCM];
        end
        `UDBS_IDX_CTRLB: s_d.ctrlb = i_pwdata[7:0];
        `UDBS_IDX_CTRLC: s_d.ctrlc = i_pwdata[7:0];
        `UDBS_IDX_BAUDL: s_d.baud[7:0] = i_pwdata[7:0];
        `UDBS_IDX_BAUDH: s_d.baud[11:8] = i_pwdata[3:0];
        `UDBS_IDX_DATA: begin
          // Accepted only while the buffer is empty
          if (udre) begin // [R03] [R01]
            s_d.tx_hold = size_mask(i_pwdata[7:0], size_code); // [R02]
            s_d.tx_hold_v = 1'b1;
          end
        end
        default: s_d.ctrlb = s_q.ctrlb;
      endcase
    end
    // Interrupt service clears transmit-complete
    if (i_tx_done_ack) begin // [R10]
      s_d.txc = 1'b0;
    end

    // -----------------------------------------------------------------
    // Transmitter
    case (s_q.tx_st)
      UDBS_TX_IDLE: begin
        // Load the held byte once the shifter is empty
        if (s_q.tx_hold_v && s_q.ctrlb[`UDBS_CB_TXEN]) begin // [R04]
          s_d.tx_sh = s_q.tx_hold;
          s_d.tx_hold_v = 1'b0;
          s_d.tx_par = (^s_q.tx_hold) ^ s_q.ctrlc[`UDBS_CC_PODD];
          s_d.tx_st = UDBS_TX_START;
          s_d.tx_os = 4'h0;
          s_d.tx_bit = 3'd0;
        end
      end
      default: begin
        if (brg_tick) begin
          s_d.tx_os = s_q.tx_os + 4'h1;
          if (s_q.tx_os == os_last) begin
            s_d.tx_os = 4'h0;
            case (s_q.tx_st)
              UDBS_TX_START: s_d.tx_st = UDBS_TX_DATA;
              UDBS_TX_DATA: begin
                s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                s_d.tx_bit = s_q.tx_bit + 3'd1;
                if (s_q.tx_bit == last_bit(size_code)) begin
                  s_d.tx_st = pen ? UDBS_TX_PAR : UDBS_TX_STOP;
                end
              end
              UDBS_TX_PAR: s_d.tx_st = UDBS_TX_STOP;
              UDBS_TX_STOP: begin
                if (s_q.ctrlc[`UDBS_CC_STOP2]) begin
                  s_d.tx_st = UDBS_TX_STOP2;
                end else begin
                  s_d.tx_st = UDBS_TX_IDLE;
                end
              end
              default: s_d.tx_st = UDBS_TX_IDLE;
            endcase
            // Frame finished with nothing new held; set beats clear
            if (s_d.tx_st == UDBS_TX_IDLE && !s_d.tx_hold_v) begin // [R09]
              s_d.txc = 1'b1;
            end
          end
        end
      end
    endcase
    s_d.tx_pin = tx_level(s_d.tx_st, s_d.tx_sh[0], s_d.tx_par); // [R04]

    // -----------------------------------------------------------------
    // Receiver
    case (s_q.rx_st)
      UDBS_RX_IDLE: begin
        if (s_q.ctrlb[`UDBS_CB_RXEN] && !rx_in) begin
          s_d.rx_st = UDBS_RX_START;
          s_d.rx_os = 4'h0;
          s_d.rx_bit = 3'd0;
          s_d.rx_sh = 8'h00;
          s_d.rx_pe = 1'b0;
          s_d.rx_drop = 1'b0;
          // Full FIFO plus a waiting character: overrun, drop new one
          if (s_q.count == 2'd2 && s_q.wait_v) begin // [R14]
            s_d.wait_ch.dor = 1'b1;
            s_d.rx_drop = 1'b1;
          end
        end
      end
      default: begin
        if (brg_tick) begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == os_mid) begin
            case (s_q.rx_st)
              UDBS_RX_START: begin
                if (rx_in) begin
                  s_d.rx_st = UDBS_RX_IDLE; // False start
                end
              end
              UDBS_RX_DATA: s_d.rx_sh[s_q.rx_bit] = rx_in;
              UDBS_RX_PAR: begin
                // Mismatch kept only because checking is on now
                s_d.rx_pe = (^s_q.rx_sh) ^ rx_in ^
                  s_q.ctrlc[`UDBS_CC_PODD]; // [R15]
              end
              default: begin
                ch.data = size_mask(s_q.rx_sh, size_code); // [R02]
                ch.fe = !rx_in; // [R13]
                ch.pe = s_q.rx_pe;
                ch.dor = 1'b0;
                s_d.rx_st = UDBS_RX_IDLE;
                // Filter drops frames whose top bit marks no address
                if (!s_q.rx_drop && !s_q.wait_v &&
                    !(s_q.mpcm && !ch.data[last_bit(size_code)])) begin
                  s_d.wait_ch = ch; // [R21]
                  s_d.wait_v = 1'b1;
                end
              end
            endcase
          end else if (s_q.rx_os == os_last) begin
            s_d.rx_os = 4'h0;
            case (s_q.rx_st)
              UDBS_RX_START: s_d.rx_st = UDBS_RX_DATA;
              UDBS_RX_DATA: begin
                s_d.rx_bit = s_q.rx_bit + 3'd1;
                if (s_q.rx_bit == last_bit(size_code)) begin
                  s_d.rx_st = pen ? UDBS_RX_PAR : UDBS_RX_STOP;
                end
              end
              default: s_d.rx_st = UDBS_RX_STOP;
            endcase
          end
        end
      end
    endcase

    // -----------------------------------------------------------------
    // Receive FIFO: any data access pops, then the waiting char enters
    if (data_acc && s_q.count != 2'd0) begin // [R05] [R16]
      s_d.fifo[0] = s_q.fifo[1];
      s_d.fifo[1] = '0;
      s_d.count = s_q.count - 2'd1;
    end
    if (s_d.wait_v && s_d.count != 2'd2) begin
      s_d.fifo[s_d.count[0]] = s_d.wait_ch;
      s_d.count = s_d.count + 2'd1;
      s_d.wait_v = 1'b0;
    end
    // Receiver off flushes buffer and its error flags
    if (!s_q.ctrlb[`UDBS_CB_RXEN]) begin // [R08] [R22]
      s_d.count = 2'd0;
      s_d.wait_v = 1'b0;
      s_d.fifo = '0;
      s_d.rx_st = UDBS_RX_IDLE;
    end
  end

  // ===================================================================
  // State register with synchronous reset
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q <= '0; // [R07]
      s_q.ctrlc <= `UDBS_CTRLC_RST;
      s_q.ctrlb <= `UDBS_CTRLB_RST;
      s_q.tx_pin <= 1'b1;
      s_q.rx_meta <= 1'b1;
      s_q.rx_sync <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ===================================================================
  // Outputs
  assign o_prdata = s_q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_txd = s_q.tx_pin;
  // Interrupt requests gated by their enables
  assign o_irq_rx = s_q.ctrlb[`UDBS_CB_RXIE] && rxc; // [R12]
  assign o_irq_tx = s_q.ctrlb[`UDBS_CB_TXIE] && s_q.txc; // [R12]
  assign o_irq_empty = s_q.ctrlb[`UDBS_CB_EMIE] && udre; // [R12]

  // ===================================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence data_write_s;
    access && i_pwrite && mapped && idx == `UDBS_IDX_DATA;
  endsequence
  sequence tx_load_s;
    s_q.tx_st == UDBS_TX_IDLE && s_q.tx_hold_v &&
      s_q.ctrlb[`UDBS_CB_TXEN];
  endsequence

  write_ignored_a: assert property ( // [R03]
    data_write_s ##0 !udre |=> $stable(s_q.tx_hold))
    else $error("data write taken while buffer full");
  write_taken_a: assert property ( // [R11]
    data_write_s ##0 udre |=> !udre ##0
      s_q.tx_hold == size_mask($past(i_pwdata[7:0]), size_code))
    else $error("accepted write did not fill the buffer");
  status_reset_a: assert property ( // [R07]
    $fell(i_rst) |-> status_val == `UDBS_STATUS_RST)
    else $error("status wrong after reset");
  tx_load_a: assert property ( // [R04]
    tx_load_s |=> s_q.tx_st == UDBS_TX_START && !o_txd && udre)
    else $error("held byte not moved to shifter");
  rx_flush_a: assert property ( // [R22]
    !s_q.ctrlb[`UDBS_CB_RXEN] |=> !rxc && status_val[4:2] == 3'b000)
    else $error("receiver off did not flush");
  fifo_pop_a: assert property ( // [R05]
    data_acc && s_q.count == 2'd2 && !s_q.wait_v &&
      s_q.ctrlb[`UDBS_CB_RXEN] |=> s_q.count == 2'd1)
    else $error("data access did not advance the FIFO");
  upper_zero_a: assert property ( // [R02]
    rxc |-> size_mask(s_q.fifo[0].data, size_code) == s_q.fifo[0].data ||
      $changed(size_code))
    else $error("unused upper bits not zero");
  spi_reserved_a: assert property ( // [R18]
    spi_mode |-> status_val[4:2] == 3'b000)
    else $error("error bits visible in SPI mode");
  txc_clear_a: assert property ( // [R10]
    i_tx_done_ack && s_q.tx_st == UDBS_TX_IDLE |=> !s_q.txc)
    else $error("transmit-complete not cleared on service");
  irq_gate_a: assert property ( // [R12]
    (s_q.ctrlb[`UDBS_CB_TXIE] || !o_irq_tx) &&
      (s_q.ctrlb[`UDBS_CB_RXIE] || !o_irq_rx) &&
      (s_q.ctrlb[`UDBS_CB_EMIE] || !o_irq_empty))
    else $error("interrupt raised while disabled");

endmodule // udbs_core

// ==== pkg/udbs_cfg.svh ====
// Offsets, field positions, reset values and counts of the serial buffer
//
// Contract
// [R01] Data address writes transmit, reads receive buffer
// [R02] Short characters: upper bits ignored, read zero
// [R03] Data writes ignored while buffer-empty flag clear
// [R04] Held byte moves to idle shifter, shifts out
// [R05] Two-entry receive FIFO advances on every access
// [R06] Software avoids bit instructions on data register
// [R07] Status reads 0x20 after reset
// [R08] Receive-complete tracks unread data; disable flushes
// [R09] Transmit-complete set when frame done, buffer empty
// [R10] Transmit-complete cleared by service or writing one
// [R11] Buffer-empty flag shows transmit buffer can accept
// [R12] Three flags raise interrupts gated by enables
// [R13] Frame error follows head character stop bit
// [R14] Overrun on full FIFO, waiting char, start
// [R15] Parity error for head character when checked
// [R16] Error flags travel with character until read
// [R17] Software writes zeros into error flag bits
// [R18] Error flags reserved in master SPI mode
// [R19] Divider zero gives clock/16 or clock/8
// [R20] Double speed changes divisor sixteen to eight
// [R21] Multiprocessor filter drops non-address frames
// [R22] Receiver disable flushes buffer, invalidates errors
// [R23] Rate is clock / (16 or 8)*(divider+1)
`ifndef UDBS_CFG_SVH
`define UDBS_CFG_SVH

// =====================================================================
// Register indices; byte address is four times the index
`define UDBS_IDX_STATUS 8'hc0
`define UDBS_IDX_CTRLB 8'hc1
`define UDBS_IDX_CTRLC 8'hc2
`define UDBS_IDX_BAUDL 8'hc4
`define UDBS_IDX_BAUDH 8'hc5
`define UDBS_IDX_DATA 8'hc6

// =====================================================================
// Status field positions
`define UDBS_ST_RXC 7
`define UDBS_ST_TXC 6
`define UDBS_ST_UDRE 5
`define UDBS_ST_FE 4
`define UDBS_ST_DOR 3
`define UDBS_ST_PE 2
`define UDBS_ST_U2X 1
`define UDBS_ST_MPCM 0

// Control B fields: interrupt enables and unit enables
`define UDBS_CB_RXIE 7
`define UDBS_CB_TXIE 6
`define UDBS_CB_EMIE 5
`define UDBS_CB_RXEN 4
`define UDBS_CB_TXEN 3
// Control C fields: mode, parity, stop bits, size
`define UDBS_CC_MODE_HI 7
`define UDBS_CC_MODE_LO 6
`define UDBS_CC_PEN 5
`define UDBS_CC_PODD 4
`define UDBS_CC_STOP2 3
`define UDBS_CC_SIZE_HI 2
`define UDBS_CC_SIZE_LO 1
`define UDBS_MODE_SPI 2'b11

// =====================================================================
// Reset values
`define UDBS_STATUS_RST 8'h20
`define UDBS_CTRLB_RST 8'h00
`define UDBS_CTRLC_RST 8'h06

// Oversampling: last tick index and mid-bit sample tick
`define UDBS_OS_LAST_NORM 4'hf
`define UDBS_OS_LAST_DBL 4'h7
`define UDBS_OS_MID_NORM 4'h7
`define UDBS_OS_MID_DBL 4'h3

`endif

// ==== pkg/udbs_pkg.sv ====
// Types shared by the serial data buffer and status logic
package udbs_pkg;

  // Transmit sequence, Gray coded along the frame
  typedef enum logic [2:0] {
    UDBS_TX_IDLE = 3'b000,
    UDBS_TX_START = 3'b001,
    UDBS_TX_DATA = 3'b011,
    UDBS_TX_PAR = 3'b010,
    UDBS_TX_STOP = 3'b110,
    UDBS_TX_STOP2 = 3'b111
  } udbs_tx_e;

  // Receive sequence, Gray coded along the frame
  typedef enum logic [2:0] {
    UDBS_RX_IDLE = 3'b000,
    UDBS_RX_START = 3'b001,
    UDBS_RX_DATA = 3'b011,
    UDBS_RX_PAR = 3'b010,
    UDBS_RX_STOP = 3'b110
  } udbs_rx_e;

  // One received character with the flags that travel with it
  typedef struct packed {
    logic dor;
    logic fe;
    logic pe;
    logic [7:0] data;
  } udbs_char_s;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] ctrlb;
    logic [7:0] ctrlc;
    logic [11:0] baud;
    logic u2x;
    logic mpcm;
    logic txc;
    logic [11:0] brg_cnt;
    logic [7:0] tx_hold;
    logic tx_hold_v;
    udbs_tx_e tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [3:0] tx_os;
    logic tx_par;
    logic tx_pin;
    logic rx_meta;
    logic rx_sync;
    udbs_rx_e rx_st;
    logic [3:0] rx_os;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_pe;
    logic rx_drop;
    udbs_char_s [1:0] fifo;
    logic [1:0] count;
    udbs_char_s wait_ch;
    logic wait_v;
    logic [31:0] prdata;
  } udbs_state_s;

endpackage

// ==== test/udbs_remote.sv ====
// Remote serial transceiver model facing the transmit and receive pins
`timescale 1ns/1ns
module udbs_remote (
  input wire logic i_clk_sys, // System clock, used as time base
  input wire logic i_txd, // Line from the block
  output logic o_rxd // Line into the block
);
  // ==================================================================
  // Frame settings, changed by the bench between frames
  int bit_clks = 16; // Clocks per bit
  int nbits = 8; // Data bits per frame
  logic par_on = 1'b0; // Parity bit sent and expected
  logic [7:0] rx_q[$]; // Characters taken from the transmit line

  // Line idles at the mark level
  initial o_rxd = 1'b1;

  // ==================================================================
  // Send one frame; bad_par and bad_stop corrupt it on purpose
  task automatic send(input logic [7:0] d, input logic bad_par,
      input logic bad_stop);
    logic p;
    p = ^(d & 8'((1 << nbits) - 1)) ^ bad_par;
    @(posedge i_clk_sys);
    o_rxd <= 1'b0;
    repeat (bit_clks) @(posedge i_clk_sys);
    for (int i = 0; i < nbits; i++) begin
      o_rxd <= d[i];
      repeat (bit_clks) @(posedge i_clk_sys);
    end
    // Even parity bit only when parity is on
    if (par_on) begin
      o_rxd <= p;
      repeat (bit_clks) @(posedge i_clk_sys);
    end
    o_rxd <= ~bad_stop;
    repeat (bit_clks) @(posedge i_clk_sys);
    o_rxd <= 1'b1;
  endtask

  // ==================================================================
  // Receiver: samples mid-bit, keeps frames with a good stop bit
  always begin
    logic [7:0] d;
    @(negedge i_txd);
    d = 8'h00;
    repeat (bit_clks / 2) @(posedge i_clk_sys);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge i_clk_sys);
      d[i] = i_txd;
    end
    if (par_on) begin
      repeat (bit_clks) @(posedge i_clk_sys);
    end
    repeat (bit_clks) @(posedge i_clk_sys);
    if (i_txd === 1'b1) begin
      rx_q.push_back(d);
    end
  end
endmodule // udbs_remote

// ==== test/tb.sv ====
// Self-checking bench for the serial data buffer and status logic
`timescale 1ns/1ns
`include "udbs_cfg.svh"
module tb;
  import udbs_pkg::*;
  // ==================================================================
  // Register byte addresses
  localparam logic [11:0] A_ST = {2'b00, `UDBS_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_CB = {2'b00, `UDBS_IDX_CTRLB, 2'b00};
  localparam logic [11:0] A_CC = {2'b00, `UDBS_IDX_CTRLC, 2'b00};
  localparam logic [11:0] A_BL = {2'b00, `UDBS_IDX_BAUDL, 2'b00};
  localparam logic [11:0] A_DT = {2'b00, `UDBS_IDX_DATA, 2'b00};
  localparam logic [11:0] A_UN = A_DT + 12'h004; // Unmapped word

`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end

  // ==================================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic ack = 1'b0; // Transmit-complete service pulse
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic txd;
  logic irq_rx;
  logic irq_tx;
  logic irq_empty;
  logic [31:0] rdat; // Last read data
  logic serr; // Last error response
  int mismatches = 0;
  int comparisons = 0;

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  udbs_core #(.BAUD_W(12)) dut_u (
    .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rxd(rxd), .o_txd(txd), .i_tx_done_ack(ack), .o_irq_rx(irq_rx),
    .o_irq_tx(irq_tx), .o_irq_empty(irq_empty)
  );

  udbs_remote remote_u (.i_clk_sys(clk), .i_txd(txd), .o_rxd(rxd));

  // ==================================================================
  // One APB transfer: setup, access until ready, then release
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  // Read and compare under a mask
  task automatic chk(input logic [11:0] a, input logic [7:0] e,
      input logic [7:0] m, input string nm);
    xfer(1'b0, a, 8'h00);
    `CHK(nm, e & m, rdat[7:0] & m)
  endtask

  // Poll status until transmit-complete shows
  task automatic wait_txc();
    int n;
    n = 0;
    do begin
      xfer(1'b0, A_ST, 8'h00);
      n++;
    end while (rdat[6] !== 1'b1 && n < 300);
    `CHK("txc wait", 1'b1, rdat[6])
  endtask

  // Send 0x01 and time the high data bit in clocks
  task automatic meas(input int e, input logic [7:0] st, input string nm);
    int n;
    n = 0;
    wr(A_DT, 8'h01);
    @(posedge txd);
    @(negedge clk);
    while (txd === 1'b1) begin
      n++;
      @(negedge clk);
    end
    `CHK(nm, e, n)
    @(posedge clk);
    wait_txc();
    wr(A_ST, st);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  // ==================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(A_ST, 8'h20, 8'hff, "status reset");
    chk(A_CC, 8'h06, 8'hff, "ctrlc reset");
    chk(A_UN, 8'h00, 8'hff, "unmapped data");
    `CHK("unmapped err", 1'b1, serr)
    wr(A_CB, 8'hf8);
    `CHK("irq empty", 1'b1, irq_empty)
    // Transmit: one in shifter, one held, third refused
    wr(A_DT, 8'ha5);
    wr(A_DT, 8'h3c);
    chk(A_ST, 8'h00, 8'hff, "busy status");
    `CHK("irq empty busy", 1'b0, irq_empty)
    wr(A_DT, 8'h77);
    wait_txc();
    chk(A_ST, 8'h60, 8'hff, "tx done status");
    `CHK("irq tx", 1'b1, irq_tx)
    `CHK("tx count", 2, remote_u.rx_q.size())
    `CHK("tx first", 8'ha5, remote_u.rx_q[0])
    `CHK("tx second", 8'h3c, remote_u.rx_q[1])
    wr(A_ST, 8'h40);
    chk(A_ST, 8'h20, 8'hff, "w1c status");
    wr(A_DT, 8'h11);
    wait_txc();
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    chk(A_ST, 8'h20, 8'hff, "ack status");
    // Bit timing: normal, double speed, larger divider
    meas(16, 8'h40, "bit normal");
    wr(A_ST, 8'h02);
    remote_u.bit_clks = 8;
    meas(8, 8'h42, "bit double");
    wr(A_ST, 8'h40);
    wr(A_BL, 8'h02);
    remote_u.bit_clks = 48;
    meas(48, 8'h40, "bit div2");
    wr(A_BL, 8'h00);
    remote_u.bit_clks = 16;
    // Receive FIFO with overrun on the waiting character
    remote_u.send(8'h81, 1'b0, 1'b0);
    remote_u.send(8'h82, 1'b0, 1'b0);
    remote_u.send(8'h83, 1'b0, 1'b0);
    remote_u.send(8'h84, 1'b0, 1'b0);
    chk(A_ST, 8'ha0, 8'hff, "fifo full");
    `CHK("irq rx", 1'b1, irq_rx)
    chk(A_DT, 8'h81, 8'hff, "rx first");
    chk(A_DT, 8'h82, 8'hff, "rx second");
    chk(A_ST, 8'ha8, 8'hff, "overrun");
    chk(A_DT, 8'h83, 8'hff, "rx third");
    chk(A_ST, 8'h20, 8'hff, "rx empty");
    // Parity error, hidden in master SPI mode
    wr(A_CC, 8'h26);
    remote_u.par_on = 1'b1;
    remote_u.send(8'h33, 1'b1, 1'b0);
    chk(A_ST, 8'ha4, 8'hff, "parity err");
    wr(A_CC, 8'he6);
    chk(A_ST, 8'ha0, 8'hff, "spi hidden");
    wr(A_CC, 8'h26);
    chk(A_DT, 8'h33, 8'hff, "rx parity");
    remote_u.send(8'h34, 1'b0, 1'b0);
    chk(A_ST, 8'ha0, 8'hff, "parity ok");
    chk(A_DT, 8'h34, 8'hff, "rx good");
    // Multiprocessor filter keeps address frames only
    wr(A_CC, 8'h06);
    remote_u.par_on = 1'b0;
    wr(A_ST, 8'h01);
    remote_u.send(8'h12, 1'b0, 1'b0);
    remote_u.send(8'h92, 1'b0, 1'b0);
    chk(A_DT, 8'h92, 8'hff, "rx address");
    chk(A_ST, 8'h21, 8'hff, "filter empty");
    wr(A_ST, 8'h00);
    // Any data access pops the head, a write too
    remote_u.send(8'h41, 1'b0, 1'b0);
    remote_u.send(8'h42, 1'b0, 1'b0);
    wr(A_DT, 8'h99);
    chk(A_DT, 8'h42, 8'hff, "pop by write");
    wait_txc();
    wr(A_ST, 8'h40);
    // Five-bit characters both ways
    wr(A_CC, 8'h00);
    remote_u.nbits = 5;
    remote_u.send(8'hff, 1'b0, 1'b0);
    chk(A_DT, 8'h1f, 8'hff, "rx short");
    wr(A_DT, 8'hca);
    wait_txc();
    `CHK("tx short", 8'h0a, remote_u.rx_q[$])
    wr(A_ST, 8'h40);
    // Frame error, then receiver disable flushes
    wr(A_CC, 8'h06);
    remote_u.nbits = 8;
    remote_u.send(8'h5a, 1'b0, 1'b1);
    chk(A_ST, 8'hb0, 8'hff, "frame err");
    wr(A_CB, 8'he8);
    chk(A_ST, 8'h20, 8'hff, "flushed");
    `CHK("irq rx off", 1'b0, irq_rx)
    stop_test();
  end
endmodule // tb
